// ===== rtl/mna_cfg.svh
/*
  Constants of the microprogram next-address block: widths, reset values
  and the opcode figures of the next-address instruction set.
  Assumes it is included by its bare name from the rtl folder.
*/
`ifndef MNA_CFG_SVH
`define MNA_CFG_SVH

// -----------------------------------------------------------------------
// widths and reset values
// -----------------------------------------------------------------------
`define MNA_ADDR_W       16
`define MNA_MWAY_W       4
`define MNA_STACK_DEPTH  33
`define MNA_RST_ADDR     16'h0000
`define MNA_RST_PC       16'h0001
`define MNA_RST_CNT      16'h0000
`define MNA_CNT_ONE      16'h0001

// -----------------------------------------------------------------------
// opcode figures
// -----------------------------------------------------------------------
`define MNA_OP_LEAVE_DIRECT_IF_TRUE    6'h02
`define MNA_OP_DEC_BRANCH_IF_TRUE    6'h03
`define MNA_OP_XTCC_A    6'h06
`define MNA_OP_DJCC_A    6'h07
`define MNA_OP_XTCC_M    6'h0A
`define MNA_OP_DJCC_M    6'h0B
`define MNA_OP_RET_T     6'h0E
`define MNA_OP_DJCC_S    6'h0F
`define MNA_OP_CNC_D     6'h11
`define MNA_OP_LEAVE_DIRECT_IF_FALSE    6'h12
`define MNA_OP_DJNC_D    6'h13
`define MNA_OP_CALL_ALT_IF_FALSE     6'h15
`define MNA_OP_XTNC_A    6'h16
`define MNA_OP_DJNC_A    6'h17
`define MNA_OP_CALL_MULTIWAY_IF_FALSE     6'h19
`define MNA_OP_XTNC_M    6'h1A
`define MNA_OP_DJNC_M    6'h1B
`define MNA_OP_CALL_TOP_IF_FALSE     6'h1D
`define MNA_OP_RET_F     6'h1E
`define MNA_OP_DJNC_S    6'h1F
`define MNA_OP_EXIT_D    6'h22
`define MNA_OP_DEC_BRANCH_DIRECT    6'h23
`define MNA_OP_EXIT_A    6'h26
`define MNA_OP_DJMP_A    6'h27
`define MNA_OP_EXIT_M    6'h2A
`define MNA_OP_DJMP_M    6'h2B
`define MNA_OP_RET       6'h2E
`define MNA_OP_DEC_BRANCH_TOP    6'h2F
`define MNA_OP_FOR_D     6'h31
`define MNA_OP_LOOP      6'h33
`define MNA_OP_POP_D     6'h34
`define MNA_OP_PUSH_D    6'h35
`define MNA_OP_FOR_A     6'h37
`define MNA_OP_POP_C     6'h38
`define MNA_OP_PUSH_C    6'h39
`define MNA_OP_SWAP      6'h3A

`endif

// ===== rtl/mna_pkg.sv
/*
  Types of the microprogram next-address block.
  Assumes mna_cfg.svh is visible on the include path.
*/
`include "mna_cfg.svh"

package mna_pkg;

  // source of a jump target, chosen by opcode bits 3..2
  typedef enum logic [1:0] {
    MNA_SRC_DIRECT = 2'h0,
    MNA_SRC_ALT    = 2'h1,
    MNA_SRC_MULTI  = 2'h2,
    MNA_SRC_TOP    = 2'h3
  } mna_src_t;

endpackage : mna_pkg

// ===== rtl/mna_stack.sv
/*
  Subroutine stack of the next-address block: the top entry is held in a
  register, deeper entries in a small array.
  Assumes at most one of push, pop and replace per cycle; a push on a full
  stack or a pop on an empty one is ignored.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mna_cfg.svh"

module mna_stack
  import mna_pkg::*;
#(
  parameter int DW    = `MNA_ADDR_W,
  parameter int DEPTH = `MNA_STACK_DEPTH
)(
  input  wire logic          mclk,
  input  wire logic          nrst,
  input  wire logic          push,
  input  wire logic          pop,
  input  wire logic          replace,
  input  wire logic [DW-1:0] wrData,
  output var  logic [DW-1:0] top_r,
  output var  logic [$clog2(DEPTH+1)-1:0] depth_r,
  output var  logic          empty_r,
  output var  logic          full_r
);

  localparam int PW = $clog2(DEPTH+1);

  logic [DW-1:0] mem [DEPTH];
  logic [DW-1:0] top_nxt;
  logic [PW-1:0] depth_nxt;
  logic          doPush;
  logic          doPop;

  // -----------------------------------------------------------------------
  // next top and depth
  // -----------------------------------------------------------------------
  always_comb
  begin
    doPush    = push && !full_r;
    doPop     = pop && !empty_r;
    top_nxt   = top_r;
    depth_nxt = depth_r;
    if (doPush)
    begin
      top_nxt   = wrData;
      depth_nxt = depth_r + PW'(1);
    end
    else if (doPop)
    begin
      // the entry below the top becomes the new top
      top_nxt   = (depth_r > PW'(1)) ? mem[depth_r - PW'(2)] : '0;
      depth_nxt = depth_r - PW'(1);
    end
    else if (replace && !empty_r)
    begin
      top_nxt = wrData;
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      top_r   <= '0;
      depth_r <= '0;
      empty_r <= 1'b1;
      full_r  <= 1'b0;
    end
    else
    begin
      top_r   <= top_nxt;
      depth_r <= depth_nxt;
      empty_r <= (depth_nxt == '0);
      full_r  <= (depth_nxt == PW'(DEPTH));
    end
  end

  // the old top sinks into the array on a push; no reset, data only
  always_ff @(posedge mclk)
  begin
    if (doPush && depth_r != '0)
      mem[depth_r - PW'(1)] <= top_r;
  end

endmodule : mna_stack

`default_nettype wire

// ===== rtl/mna_next_addr.sv
/*
  Next-address logic of a 16-bit microprogram sequencer: next microaddress,
  subroutine stack and loop counter.
  Assumes synchronous inputs and a microprogram store on yAddr_r.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mna_cfg.svh"

module mna_next_addr
  import mna_pkg::*;
#(
  parameter int AW    = `MNA_ADDR_W,
  parameter int MW    = `MNA_MWAY_W,
  parameter int DEPTH = `MNA_STACK_DEPTH
)(
  input  wire logic          mclk,
  input  wire logic          nrst,
  input  wire logic [5:0]    opcode,
  input  wire logic          branchCondition,
  input  wire logic [AW-1:0] dIn,
  input  wire logic [AW-1:0] aIn,
  input  wire logic [MW-1:0] mIn,
  output var  logic [AW-1:0] yAddr_r,
  output var  logic [AW-1:0] dOut_r,
  output var  logic          dOe_r,
  output var  logic [AW-1:0] loopCount_r,
  output var  logic          stackEmpty_r,
  output var  logic          stackFull_r
);

  localparam int PW = $clog2(DEPTH+1);
  // -----------------------------------------------------------------------
  // sequencing state
  // -----------------------------------------------------------------------
  logic [AW-1:0] pc_r;
  logic [AW-1:0] pc_nxt;
  logic [AW-1:0] yAddr_nxt;
  logic [AW-1:0] loopCount_nxt;
  logic [AW-1:0] dOut_nxt;
  logic          dOe_nxt;
  logic [AW-1:0] top;
  logic [PW-1:0] depth;
  logic          stPush;
  logic          stPop;
  logic          stRepl;
  logic [AW-1:0] stData;
  logic [AW-1:0] target;
  logic          cntOne;
  logic          cc;
  mna_src_t      src;

  assign cc     = branchCondition;
  assign cntOne = (loopCount_r == `MNA_CNT_ONE);
  assign src    = mna_src_t'(opcode[3:2]);
  // jump target chosen by the two source bits of the opcode
  always_comb
  begin
    unique case (src)
      MNA_SRC_DIRECT: target = dIn;
      MNA_SRC_ALT:    target = aIn;
      MNA_SRC_MULTI:  target = {dIn[AW-1:MW], mIn};
      MNA_SRC_TOP:    target = top;
    endcase
  end

  // -----------------------------------------------------------------------
  // opcode decode
  // -----------------------------------------------------------------------
  // default is continue: the PC already holds the incremented address
  always_comb
  begin
    yAddr_nxt     = pc_r;
    loopCount_nxt = loopCount_r;
    dOut_nxt      = dOut_r;
    dOe_nxt       = 1'b0;
    stPush        = 1'b0;
    stPop         = 1'b0;
    stRepl        = 1'b0;
    stData        = pc_r;
    unique case (opcode)
      `MNA_OP_CNC_D, `MNA_OP_CALL_ALT_IF_FALSE, `MNA_OP_CALL_MULTIWAY_IF_FALSE:
      begin
        if (!cc)
        begin
          yAddr_nxt = target;
          stPush    = 1'b1;
        end
      end
      `MNA_OP_CALL_TOP_IF_FALSE:
      begin
        // coroutine call: the PC takes the place of the top entry
        if (!cc)
        begin
          yAddr_nxt = top;
          stRepl    = 1'b1;
        end
      end
      `MNA_OP_EXIT_D, `MNA_OP_EXIT_A, `MNA_OP_EXIT_M:
      begin
        yAddr_nxt = target;
        stPop     = 1'b1;
      end
      `MNA_OP_LEAVE_DIRECT_IF_TRUE, `MNA_OP_XTCC_A, `MNA_OP_XTCC_M:
      begin
        if (cc)
        begin
          yAddr_nxt = target;
          stPop     = 1'b1;
        end
      end
      `MNA_OP_LEAVE_DIRECT_IF_FALSE, `MNA_OP_XTNC_A, `MNA_OP_XTNC_M:
      begin
        if (!cc)
        begin
          yAddr_nxt = target;
          stPop     = 1'b1;
        end
      end
      `MNA_OP_DEC_BRANCH_DIRECT, `MNA_OP_DJMP_A, `MNA_OP_DJMP_M:
      begin
        if (!cntOne)
        begin
          loopCount_nxt = loopCount_r - AW'(1);
          yAddr_nxt     = target;
        end
      end
      `MNA_OP_DEC_BRANCH_TOP:
      begin
        loopCount_nxt = loopCount_r - AW'(1);
        if (!cntOne)
          yAddr_nxt = top;
        else
          stPop = 1'b1;
      end
      `MNA_OP_DEC_BRANCH_IF_TRUE, `MNA_OP_DJCC_A, `MNA_OP_DJCC_M, `MNA_OP_DJCC_S:
      begin
        loopCount_nxt = loopCount_r - AW'(1);
        if (cc && !cntOne)
          yAddr_nxt = target;
        else if (src == MNA_SRC_TOP)
          stPop = 1'b1;
      end
      `MNA_OP_DJNC_D, `MNA_OP_DJNC_A, `MNA_OP_DJNC_M, `MNA_OP_DJNC_S:
      begin
        loopCount_nxt = loopCount_r - AW'(1);
        if (!cc && !cntOne)
          yAddr_nxt = target;
        else if (src == MNA_SRC_TOP)
          stPop = 1'b1;
      end
      `MNA_OP_RET, `MNA_OP_RET_T, `MNA_OP_RET_F:
      begin
        if (opcode == `MNA_OP_RET || (opcode == `MNA_OP_RET_T) == cc)
        begin
          yAddr_nxt = top;
          stPop     = 1'b1;
        end
      end
      `MNA_OP_FOR_D, `MNA_OP_FOR_A:
      begin
        stPush        = 1'b1;
        loopCount_nxt = (opcode == `MNA_OP_FOR_D) ? dIn : aIn;
      end
      `MNA_OP_LOOP: stPush = 1'b1;
      `MNA_OP_POP_D:
      begin
        stPop    = 1'b1;
        dOut_nxt = top;
        dOe_nxt  = 1'b1;
      end
      `MNA_OP_POP_C:
      begin
        stPop         = 1'b1;
        loopCount_nxt = top;
      end
      `MNA_OP_PUSH_D:
      begin
        stPush = 1'b1;
        stData = dIn;
      end
      `MNA_OP_PUSH_C:
      begin
        stPush = 1'b1;
        stData = loopCount_r;
      end
      `MNA_OP_SWAP:
      begin
        stRepl        = 1'b1;
        stData        = loopCount_r;
        loopCount_nxt = top;
      end
      default: yAddr_nxt = pc_r;
    endcase
    pc_nxt = yAddr_nxt + AW'(1);
  end

  // all sequencing state changes together at the clock edge
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      yAddr_r     <= `MNA_RST_ADDR;
      pc_r        <= `MNA_RST_PC;
      loopCount_r <= `MNA_RST_CNT;
      dOut_r      <= '0;
      dOe_r       <= 1'b0;
    end
    else
    begin
      yAddr_r     <= yAddr_nxt;
      pc_r        <= pc_nxt;
      loopCount_r <= loopCount_nxt;
      dOut_r      <= dOut_nxt;
      dOe_r       <= dOe_nxt;
    end
  end

  // -----------------------------------------------------------------------
  // stack
  // -----------------------------------------------------------------------
  // push and pop land at the same edge as the new address
  mna_stack #(
    .DW    (AW),
    .DEPTH (DEPTH)
  ) uStack (
    .mclk    (mclk),
    .nrst    (nrst),
    .push    (stPush),
    .pop     (stPop),
    .replace (stRepl),
    .wrData  (stData),
    .top_r   (top),
    .depth_r (depth),
    .empty_r (stackEmpty_r),
    .full_r  (stackFull_r)
  );

  // -----------------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  chk_call_false: assert property (
    (opcode == `MNA_OP_CALL_ALT_IF_FALSE && !cc && !stackFull_r)
      |=> yAddr_r == $past(aIn) && top == $past(pc_r)
          && depth == $past(depth) + PW'(1))
    else $error("call on low condition misbehaved");
  chk_exit_pop: assert property (
    (opcode == `MNA_OP_EXIT_D && !stackEmpty_r)
      |=> yAddr_r == $past(dIn) && depth == $past(depth) - PW'(1))
    else $error("exit to direct did not jump and pop");
  chk_exit_true: assert property (
    (opcode == `MNA_OP_XTCC_M && !cc)
      |=> yAddr_r == $past(pc_r) && depth == $past(depth))
    else $error("exit if true acted on low condition");
  chk_exit_false: assert property (
    (opcode == `MNA_OP_XTNC_M && !cc && !stackEmpty_r)
      |=> yAddr_r[MW-1:0] == $past(mIn)
          && (yAddr_r >> MW) == ($past(dIn) >> MW)
          && depth == $past(depth) - PW'(1))
    else $error("exit if false to multiway wrong");
  chk_dec_branch: assert property (
    (opcode == `MNA_OP_DJMP_A)
      |=> (($past(loopCount_r) != `MNA_CNT_ONE)
            ? (yAddr_r == $past(aIn)
               && loopCount_r == $past(loopCount_r) - AW'(1))
            : (yAddr_r == $past(pc_r)
               && loopCount_r == $past(loopCount_r))))
    else $error("decrement and branch wrong");
  chk_dec_top_end: assert property (
    (opcode == `MNA_OP_DEC_BRANCH_TOP && cntOne && !stackEmpty_r)
      |=> loopCount_r == '0 && yAddr_r == $past(pc_r)
          && depth == $past(depth) - PW'(1))
    else $error("loop end to top did not pop");
  chk_dec_true: assert property (
    (opcode == `MNA_OP_DEC_BRANCH_IF_TRUE && !cc)
      |=> yAddr_r == $past(pc_r)
          && loopCount_r == $past(loopCount_r) - AW'(1))
    else $error("conditional decrement on low wrong");
  chk_dec_false: assert property (
    (opcode == `MNA_OP_DJNC_S && cc && !stackEmpty_r)
      |=> depth == $past(depth) - PW'(1) && yAddr_r == $past(pc_r))
    else $error("conditional loop to top did not pop");
  chk_return: assert property (
    (opcode == `MNA_OP_RET && !stackEmpty_r)
      |=> yAddr_r == $past(top) && depth == $past(depth) - PW'(1))
    else $error("return did not take the top entry");
  chk_for_load: assert property (
    (opcode == `MNA_OP_FOR_A && !stackFull_r)
      |=> loopCount_r == $past(aIn) && top == $past(pc_r)
          && yAddr_r == $past(pc_r))
    else $error("for-loop start wrong");
  chk_pop_drive: assert property (
    (opcode == `MNA_OP_POP_D)
      |=> dOe_r && dOut_r == $past(top)
          ##1 (dOe_r == ($past(opcode) == `MNA_OP_POP_D)))
    else $error("pop to direct bus wrong");
  chk_swap: assert property (
    (opcode == `MNA_OP_SWAP && !stackEmpty_r)
      |=> loopCount_r == $past(top) && top == $past(loopCount_r)
          && depth == $past(depth))
    else $error("swap did not exchange");
  chk_seq_inc: assert property (
    (opcode == `MNA_OP_LOOP && !stackFull_r)
      |=> yAddr_r == $past(yAddr_r) + AW'(1) && top == $past(pc_r)
          && depth == $past(depth) + PW'(1))
    else $error("loop start did not push and continue");

  cov_call_ret: cover property (
    opcode == `MNA_OP_CALL_MULTIWAY_IF_FALSE && !cc ##[1:20] opcode == `MNA_OP_RET);
  cov_loop_end: cover property (
    opcode == `MNA_OP_DEC_BRANCH_TOP && cntOne && !stackEmpty_r);
  cov_swap: cover property (opcode == `MNA_OP_SWAP && !stackEmpty_r);
  cov_full: cover property (stackFull_r);

endmodule : mna_next_addr

`default_nettype wire

// ===== testbench/mna_store_model.sv
/*
  Microprogram store model: presents the alternate-address field of the
  microword at the current microaddress on the alternate bus.
  Assumes the microaddress is registered on the rising edge of mclk.
*/
`timescale 1ns/1ps
`default_nettype none

module mna_store_model (
  input  wire logic        mclk,
  input  wire logic [15:0] yAddr_r,
  output var  logic [15:0] aIn
);
  // ----------------------------------------------------------------
  // store read
  // ----------------------------------------------------------------
  // contents are a fixed scramble of the address so the bench can
  // predict them; read half a cycle after the address settles
  initial aIn = 16'h0000;
  always @(negedge mclk)
    aIn <= {yAddr_r[7:0], yAddr_r[15:8]} ^ 16'h5A3C;
endmodule : mna_store_model

`default_nettype wire

// ===== testbench/microprogram_next_address_test.sv
/*
  Self-checking bench of the next-address block: a reference model runs
  in step with the design, directed corners first, then random opcodes.
  Assumes the design's outputs settle one cycle after each opcode.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mna_cfg.svh"

module microprogram_next_address_test;
  logic        mclk;
  logic        nrst;
  logic [5:0]  opcode;
  logic        branchCondition;
  logic [15:0] dDrv;
  logic [15:0] dBus;
  logic [15:0] aIn;
  logic [3:0]  mIn;
  logic [15:0] yAddr_r;
  logic [15:0] dOut_r;
  logic        dOe_r;
  logic [15:0] loopCount_r;
  logic        stackEmpty_r;
  logic        stackFull_r;
  int          badCount;
  int          testsRun;
  // reference model state
  logic [15:0] eY;
  logic [15:0] ePc;
  logic [15:0] eCnt;
  logic [15:0] eOut;
  logic        eOe;
  logic [15:0] stk[$];
  logic [5:0]  opTab[36] = '{6'h02, 6'h03, 6'h06, 6'h07, 6'h0A, 6'h0B,
    6'h0E, 6'h0F, 6'h11, 6'h12, 6'h13, 6'h15, 6'h16, 6'h17, 6'h19, 6'h1A,
    6'h1B, 6'h1D, 6'h1E, 6'h1F, 6'h22, 6'h23, 6'h26, 6'h27, 6'h2A, 6'h2B,
    6'h2E, 6'h2F, 6'h31, 6'h33, 6'h34, 6'h35, 6'h37, 6'h38, 6'h39, 6'h3A};

  // ----------------------------------------------------------------
  // design, store model and the shared direct bus
  // ----------------------------------------------------------------
  // the device owns the bus while it presents a popped value
  assign dBus = dOe_r ? dOut_r : dDrv;

  mna_next_addr u_dut (
    .mclk(mclk), .nrst(nrst), .opcode(opcode),
    .branchCondition(branchCondition), .dIn(dBus), .aIn(aIn), .mIn(mIn),
    .yAddr_r(yAddr_r), .dOut_r(dOut_r), .dOe_r(dOe_r),
    .loopCount_r(loopCount_r), .stackEmpty_r(stackEmpty_r),
    .stackFull_r(stackFull_r)
  );

  mna_store_model u_store (.mclk(mclk), .yAddr_r(yAddr_r), .aIn(aIn));

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic closeOut;
    $display("comparisons %0d mismatches %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : closeOut

  task automatic chk(input string nm, input logic [15:0] ex,
                     input logic [15:0] got);
    testsRun++;
    if (got !== ex)
    begin
      badCount++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  function automatic logic [15:0] altField(input logic [15:0] y);
    return {y[7:0], y[15:8]} ^ 16'h5A3C;
  endfunction : altField

  task automatic resetModel;
    eY = 16'h0000;
    ePc = 16'h0001;
    eCnt = 16'h0000;
    eOut = 16'h0000;
    eOe = 1'b0;
    stk.delete();
  endtask : resetModel

  // full stack silently drops a push, empty stack drops a pop
  task automatic spush(input logic [15:0] v);
    if (stk.size() < `MNA_STACK_DEPTH)
      stk.push_back(v);
  endtask : spush

  task automatic spop;
    if (stk.size() > 0)
      void'(stk.pop_back());
  endtask : spop

  task automatic model(input logic [5:0] op, input logic cc,
                       input logic [15:0] d, input logic [15:0] a,
                       input logic [3:0] m);
    logic [15:0] tgt;
    logic [15:0] top;
    logic [15:0] ny;
    logic        c;
    top = (stk.size() > 0) ? stk[$] : 16'h0000;
    case (op[3:2])
      2'h0: tgt = d;
      2'h1: tgt = a;
      2'h2: tgt = {d[15:4], m};
      default: tgt = top;
    endcase
    c = (op[5:4] == 2'h0) ? cc : (op[5:4] == 2'h1) ? !cc : 1'b1;
    ny = ePc;
    eOe = 1'b0;
    if (op[5:4] != 2'h3)
    begin
      case (op[1:0])
        2'h1: if (c)
        begin
          ny = tgt;
          if (op[3:2] == 2'h3)
            stk[$] = ePc;
          else
            spush(ePc);
        end
        2'h2: if (c)
        begin
          ny = tgt;
          spop();
        end
        2'h3: if (c && eCnt != 16'h0001)
        begin
          ny = tgt;
          eCnt = eCnt - 16'h0001;
        end
        else
        begin
          if (op[5:4] != 2'h2 || op[3:2] == 2'h3)
            eCnt = eCnt - 16'h0001;
          if (op[3:2] == 2'h3)
            spop();
        end
        default: ;
      endcase
    end
    else
      case (op)
        6'h31: begin spush(ePc); eCnt = d; end
        6'h37: begin spush(ePc); eCnt = a; end
        6'h33: spush(ePc);
        6'h34: begin eOut = top; eOe = 1'b1; spop(); end
        6'h38: begin eCnt = top; spop(); end
        6'h35: spush(d);
        6'h39: spush(eCnt);
        6'h3A: begin stk[$] = eCnt; eCnt = top; end
        default: ;
      endcase
    eY = ny;
    ePc = ny + 16'h0001;
  endtask : model

  // compare the state left by the last edge, then issue one opcode
  task automatic step(input logic [5:0] opIn, input logic cIn,
                      input logic [15:0] dv);
    logic [5:0]  op;
    logic [3:0]  m;
    logic [15:0] d;
    chk("yAddr_r", eY, yAddr_r);
    chk("loopCount_r", eCnt, loopCount_r);
    chk("dOe_r", {15'h0000, eOe}, {15'h0000, dOe_r});
    if (eOe)
      chk("dOut_r", eOut, dOut_r);
    chk("stackEmpty_r", {15'h0000, stk.size() == 0},
        {15'h0000, stackEmpty_r});
    chk("stackFull_r", {15'h0000, stk.size() == `MNA_STACK_DEPTH},
        {15'h0000, stackFull_r});
    op = opIn;
    // an empty stack has no defined top to jump to or pop from
    if (stk.size() == 0 && (op[3:2] == 2'h3 || op == 6'h34 ||
        op == 6'h38 || op == 6'h3A))
      op = 6'h33;
    m = 4'($urandom);
    d = eOe ? eOut : dv;
    opcode = op;
    branchCondition = cIn;
    mIn = m;
    dDrv = d;
    model(op, cIn, d, altField(eY), m);
    @(negedge mclk);
  endtask : step

  // ----------------------------------------------------------------
  // watchdog and main sequence
  // ----------------------------------------------------------------
  initial
  begin
    #100000;
    badCount++;
    closeOut();
  end

  initial
  begin
    badCount = 0;
    testsRun = 0;
    nrst = 1'b0;
    opcode = 6'h00;
    branchCondition = 1'b0;
    dDrv = 16'h0000;
    mIn = 4'h0;
    void'($urandom(71965));
    resetModel();
    repeat (12) @(negedge mclk);
    nrst = 1'b1;
    // count of two: one jump back to the top, then fall out
    step(6'h31, 1'b0, 16'h0002);
    step(6'h2F, 1'b0, 16'h0000);
    step(6'h2F, 1'b0, 16'h0000);
    // one more push than the stack holds
    for (int i = 0; i < 34; i++)
      step(6'h35, 1'b0, 16'(i));
    step(6'h34, 1'b0, 16'h0000);
    step(6'h34, 1'b0, 16'h0000);
    step(6'h3A, 1'b0, 16'h0000);
    step(6'h39, 1'b0, 16'h0000);
    step(6'h38, 1'b0, 16'h0000);
    // every opcode with the condition low and high
    for (int i = 0; i < 72; i++)
      step(opTab[i / 2], i[0], 16'($urandom));
    for (int i = 0; i < 3000; i++)
    begin
      logic [5:0] rop;
      rop = opTab[$urandom_range(0, 35)];
      step(rop, 1'($urandom), (rop == 6'h31) ?
           16'($urandom_range(0, 3)) : 16'($urandom));
    end
    // reset in mid-run
    nrst = 1'b0;
    repeat (3) @(negedge mclk);
    nrst = 1'b1;
    resetModel();
    for (int i = 0; i < 300; i++)
      step(opTab[$urandom_range(0, 35)], 1'($urandom),
           16'($urandom));
    // an opcode outside the set must simply continue
    step(6'h00, 1'b1, 16'h0000);
    step(6'h33, 1'b0, 16'h0000);
    closeOut();
  end
endmodule : microprogram_next_address_test

`default_nettype wire
